/* File: hdl/rx_link_if.sv */
// serial control link between host controller and receiver
`default_nettype none
interface rx_link_if;
  logic sclk; // link clock, made by host, idle low
  logic cs_n; // frame select, active low
  logic mosi; // command data, msb first
  modport dev (input sclk, input cs_n, input mosi);
  modport host (output sclk, output cs_n, output mosi);
endinterface
`default_nettype wire

/* File: hdl/rx_mode_device.sv */
// receiver mode controller: link register slave and run mode slave fsm
//
// Decided for this implementation: the AHB-Lite register port.
`default_nettype none
module rx_mode_device (
  input wire logic hclk,
  input wire logic hresetn,
  rx_link_if.dev link,
  input wire logic startup_done,
  input wire logic sym_sync,
  input wire logic frame_sync,
  input wire logic id_done,
  input wire logic id_valid,
  input wire logic eom_detect,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic buffer_release,
  output logic rf_enable,
  output logic osc_low_precision,
  output logic self_poll_enable,
  output logic config_sel,
  output logic clkout_enable,
  output logic rx_init,
  output logic buf_clear,
  output logic buf_wr,
  output logic buf_wr_bit,
  output logic buf_lock,
  output logic id_scan_init,
  output logic irq_frame_start,
  output logic irq_id_match,
  output logic irq_eom,
  output rx_mode_pkg::rx_state_t state
);
  // ----------------------------------------
  // link input synchronisers
  // ----------------------------------------
  logic sclk_s; // synchronised link clock
  logic cs_n_s; // synchronised frame select
  logic mosi_s; // synchronised data
  sync_2ff #(.RESET_VAL(1'b0)) u_sclk (.hclk(hclk), .hresetn(hresetn),
    .async_in(link.sclk), .sync_out(sclk_s));
  sync_2ff #(.RESET_VAL(1'b1)) u_cs (.hclk(hclk), .hresetn(hresetn),
    .async_in(link.cs_n), .sync_out(cs_n_s));
  sync_2ff #(.RESET_VAL(1'b0)) u_mosi (.hclk(hclk), .hresetn(hresetn),
    .async_in(link.mosi), .sync_out(mosi_s));

  // ----------------------------------------
  // frame receiver
  // ----------------------------------------
  logic sclk_q; // previous link clock level
  logic cs_n_q; // previous frame select level
  logic [23:0] shift_q; // received bits
  logic [4:0] cnt_q; // bits received in frame
  wire logic sclk_rise = sclk_s & ~sclk_q;
  wire logic frame_end = cs_n_s & ~cs_n_q;
  wire logic frame_ok = frame_end &&
    (cnt_q == 5'(rx_mode_pkg::FRAME_BITS)) &&
    (shift_q[23:16] == rx_mode_pkg::WRITE_OPCODE);
  wire logic [7:0] wr_addr = shift_q[15:8];
  wire logic [7:0] wr_data = shift_q[7:0];

  // shift on link clock rising edges inside a frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      shift_q <= 24'h000000;
      cnt_q <= 5'h00;
    end else begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
      if (cs_n_s && !frame_end) begin
        cnt_q <= 5'h00; // idle between frames
      end else if (!cs_n_s && sclk_rise) begin
        shift_q <= {shift_q[22:0], mosi_s};
        if (cnt_q != 5'h1f) begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [7:0] mode0_q; // chip_mode_control_0
  logic [7:0] mode1_q; // chip_mode_control_1
  logic [7:0] rxctl_q; // rx_control

  // writes land on a complete write frame; others ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode0_q <= rx_mode_pkg::CHIP_MODE_CONTROL_0_RESET;
      mode1_q <= rx_mode_pkg::CHIP_MODE_CONTROL_1_RESET;
      rxctl_q <= rx_mode_pkg::RX_CONTROL_RESET;
    end else if (frame_ok) begin
      if (wr_addr == rx_mode_pkg::CHIP_MODE_CONTROL_0_ADDR) begin
        mode0_q <= wr_data;
      end
      if (wr_addr == rx_mode_pkg::CHIP_MODE_CONTROL_1_ADDR) begin
        mode1_q <= wr_data; // hold only changes here
      end
      if (wr_addr == rx_mode_pkg::RX_CONTROL_ADDR) begin
        rxctl_q <= wr_data;
      end
    end
  end

  wire logic poll_mode = mode0_q[rx_mode_pkg::OPERATING_MODE_SELECT_BIT];
  wire logic rx_en = mode0_q[rx_mode_pkg::SLAVE_RECEIVER_ENABLE_BIT];
  wire logic hold = mode1_q[rx_mode_pkg::HOLD_BIT];
  wire logic init_buf =
    rxctl_q[rx_mode_pkg::INIT_BUFFER_ON_START_BIT];
  wire logic fs_clear =
    rxctl_q[rx_mode_pkg::FRAME_START_BUFFER_CLEAR_BIT];
  wire logic mid_en = rxctl_q[rx_mode_pkg::MESSAGE_ID_SCAN_ENABLE_BIT];
  wire logic lock_en = rxctl_q[rx_mode_pkg::BUFFER_LOCK_ENABLE_BIT];

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  rx_mode_pkg::rx_state_t state_d; // next state
  logic lock_q; // buffer lock
  logic init_p; // receiver init pulse
  logic clr_p; // buffer clear pulse
  logic mid_p; // id scanner init pulse
  logic fs_p; // frame start event
  logic idm_p; // id match event
  logic eom_p; // end of message event
  logic lock_set; // lock requested at end of message
  wire logic in_hold_range = (state >= rx_mode_pkg::ST_LOCKED) &&
    (state <= rx_mode_pkg::ST_EOM_CHECK);
  wire logic in_frame = (state >= rx_mode_pkg::ST_FRAME_WAIT) &&
    (state <= rx_mode_pkg::ST_EOM_CHECK);
  wire logic storing = (state >= rx_mode_pkg::ST_BUF_INIT) &&
    (state <= rx_mode_pkg::ST_EOM_CHECK);

  // next state and one-cycle actions
  always_comb begin
    state_d = state;
    init_p = 1'b0;
    clr_p = 1'b0;
    mid_p = 1'b0;
    fs_p = 1'b0;
    idm_p = 1'b0;
    eom_p = 1'b0;
    lock_set = 1'b0;
    if (poll_mode) begin
      state_d = rx_mode_pkg::ST_POLL; // self polling
    end else if (!rx_en) begin
      state_d = rx_mode_pkg::ST_SLEEP; // slave sleep
    end else if (hold && in_hold_range) begin
      state_d = rx_mode_pkg::ST_HOLD;
    end else if (in_frame && !sym_sync) begin
      state_d = rx_mode_pkg::ST_SYM_WAIT; // sync lost
    end else begin
      case (state)
        rx_mode_pkg::ST_SLEEP, rx_mode_pkg::ST_POLL: begin
          state_d = rx_mode_pkg::ST_STARTUP;
        end
        rx_mode_pkg::ST_STARTUP: begin
          if (startup_done) begin
            state_d = rx_mode_pkg::ST_INIT;
          end
        end
        rx_mode_pkg::ST_INIT: begin
          init_p = 1'b1; // load selected config
          clr_p = init_buf;
          state_d = lock_q ? rx_mode_pkg::ST_LOCKED :
            rx_mode_pkg::ST_SYM_WAIT;
        end
        rx_mode_pkg::ST_LOCKED: begin
          if (!lock_q) begin
            state_d = rx_mode_pkg::ST_SYM_WAIT;
          end
        end
        rx_mode_pkg::ST_SYM_WAIT: begin
          if (sym_sync) begin
            state_d = rx_mode_pkg::ST_FRAME_WAIT;
          end
        end
        rx_mode_pkg::ST_FRAME_WAIT: begin
          if (frame_sync) begin
            fs_p = 1'b1; // preamble and sync seen
            state_d = rx_mode_pkg::ST_BUF_INIT;
          end
        end
        rx_mode_pkg::ST_BUF_INIT: begin
          clr_p = fs_clear;
          state_d = rx_mode_pkg::ST_MID_CHECK;
        end
        rx_mode_pkg::ST_MID_CHECK: begin
          state_d = mid_en ? rx_mode_pkg::ST_MID_INIT :
            rx_mode_pkg::ST_EOM_CHECK;
        end
        rx_mode_pkg::ST_MID_INIT: begin
          mid_p = 1'b1;
          state_d = rx_mode_pkg::ST_MID_WAIT;
        end
        rx_mode_pkg::ST_MID_WAIT: begin
          if (id_done && id_valid) begin
            idm_p = 1'b1;
            state_d = rx_mode_pkg::ST_EOM_CHECK;
          end else if (id_done) begin
            state_d = rx_mode_pkg::ST_FRAME_WAIT; // bits kept
          end
        end
        rx_mode_pkg::ST_EOM_CHECK: begin
          if (eom_detect) begin
            eom_p = 1'b1;
            lock_set = lock_en;
            state_d = lock_en ? rx_mode_pkg::ST_LOCKED :
              rx_mode_pkg::ST_SYM_WAIT;
          end
        end
        rx_mode_pkg::ST_HOLD: begin
          if (!hold) begin
            state_d = rx_mode_pkg::ST_INIT; // no start-up
          end
        end
        default: begin
          state_d = rx_mode_pkg::ST_SLEEP;
        end
      endcase
    end
  end

  // state, lock and registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= rx_mode_pkg::ST_SLEEP;
      lock_q <= 1'b0;
      rx_init <= 1'b0;
      buf_clear <= 1'b0;
      id_scan_init <= 1'b0;
      irq_frame_start <= 1'b0;
      irq_id_match <= 1'b0;
      irq_eom <= 1'b0;
      buf_wr <= 1'b0;
      buf_wr_bit <= 1'b0;
    end else begin
      state <= state_d;
      if (lock_set) begin
        lock_q <= 1'b1; // set wins over release
      end else if (buffer_release) begin
        lock_q <= 1'b0;
      end
      rx_init <= init_p;
      buf_clear <= clr_p;
      id_scan_init <= mid_p;
      irq_frame_start <= fs_p;
      irq_id_match <= idm_p;
      irq_eom <= eom_p;
      // payload only, never in lock or before sync
      buf_wr <= storing && rx_bit_valid && sym_sync;
      buf_wr_bit <= rx_bit;
    end
  end

  // ----------------------------------------
  // mode outputs
  // ----------------------------------------
  assign buf_lock = lock_q;
  assign rf_enable = (state != rx_mode_pkg::ST_SLEEP);
  assign osc_low_precision = (state == rx_mode_pkg::ST_SLEEP);
  assign self_poll_enable = (state == rx_mode_pkg::ST_POLL);
  assign config_sel = mode0_q[rx_mode_pkg::SLAVE_CONFIG_SELECT_BIT];
  assign clkout_enable = mode0_q[rx_mode_pkg::CLKOUT_ENABLE_BIT];
endmodule // rx_mode_device
`default_nettype wire

/* File: hdl/rx_mode_host.sv */
// host controller: ahb-lite command registers driving the serial link
`default_nettype none
module rx_mode_host #(
  parameter int SCLK_HALF = rx_mode_pkg::SCLK_HALF_CYC,
  parameter int GAP_CYC = rx_mode_pkg::REINIT_GAP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  rx_link_if.host link
);
  // counters are 16 bits wide; refuse what they cannot reach
  if (SCLK_HALF < 1 || SCLK_HALF > 65535 || GAP_CYC < 1 ||
      GAP_CYC > 65535) begin : g_bad_timing
    $error("rx_mode_host: bad timing parameter");
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  logic wr_pend_q; // write data phase pending
  logic [7:0] wr_ofs_q; // offset of pending write
  logic [7:0] sh0_q; // sent chip_mode_control_0
  logic [7:0] sh1_q; // sent chip_mode_control_1
  logic [15:0] cmd_q; // last accepted command word
  logic refused_q; // sticky refused flag
  logic busy; // frame or gap in progress
  wire logic addr_ph = hsel && htrans[1] && hready;
  wire logic [31:0] status_word = {8'h00, sh1_q, sh0_q, 6'h00,
    refused_q, busy};
  wire logic [31:0] rd_word =
    (haddr[7:0] == rx_mode_pkg::HOST_COMMAND_OFS) ? {16'h0000, cmd_q} :
    (haddr[7:0] == rx_mode_pkg::HOST_STATUS_OFS) ? status_word :
    32'h00000000;
  wire logic cmd_wr = wr_pend_q &&
    (wr_ofs_q == rx_mode_pkg::HOST_COMMAND_OFS);
  wire logic stat_wr = wr_pend_q &&
    (wr_ofs_q == rx_mode_pkg::HOST_STATUS_OFS);
  wire logic [7:0] c_addr = hwdata[15:8];
  wire logic [7:0] c_data = hwdata[7:0];
  wire logic running = !sh0_q[rx_mode_pkg::OPERATING_MODE_SELECT_BIT] &&
    sh0_q[rx_mode_pkg::SLAVE_RECEIVER_ENABLE_BIT] &&
    !sh1_q[rx_mode_pkg::HOLD_BIT];
  wire logic polling = sh0_q[rx_mode_pkg::OPERATING_MODE_SELECT_BIT];
  // configuration writes only in sleep or hold
  wire logic cfg_bad = (running || polling) &&
    ((c_addr == rx_mode_pkg::RX_CONTROL_ADDR) ||
     ((c_addr == rx_mode_pkg::CHIP_MODE_CONTROL_0_ADDR) &&
      (c_data[rx_mode_pkg::SLAVE_CONFIG_SELECT_BIT] !=
       sh0_q[rx_mode_pkg::SLAVE_CONFIG_SELECT_BIT])));
  // hold refused only while self polling
  wire logic hold_bad = polling &&
    (c_addr == rx_mode_pkg::CHIP_MODE_CONTROL_1_ADDR) &&
    c_data[rx_mode_pkg::HOLD_BIT];
  wire logic refuse = cmd_wr && (busy || cfg_bad || hold_bad);
  wire logic start = cmd_wr && !refuse;

  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always okay

  // bus capture, read data and host-side registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 8'h00;
      hrdata <= 32'h00000000;
      cmd_q <= 16'h0000;
      refused_q <= 1'b0;
      sh0_q <= rx_mode_pkg::CHIP_MODE_CONTROL_0_RESET;
      sh1_q <= rx_mode_pkg::CHIP_MODE_CONTROL_1_RESET;
    end else begin
      wr_pend_q <= addr_ph && hwrite;
      if (addr_ph) begin
        wr_ofs_q <= haddr[7:0];
        hrdata <= rd_word;
      end
      if (refuse) begin
        refused_q <= 1'b1; // set wins over clear
      end else if (stat_wr && hwdata[rx_mode_pkg::STATUS_REFUSED_BIT]) begin
        refused_q <= 1'b0;
      end
      if (start) begin
        cmd_q <= hwdata[15:0]; // every change is host driven
        if (c_addr == rx_mode_pkg::CHIP_MODE_CONTROL_0_ADDR) begin
          sh0_q <= c_data; // run entry is 0 then 1
        end
        if (c_addr == rx_mode_pkg::CHIP_MODE_CONTROL_1_ADDR) begin
          sh1_q <= c_data;
        end
      end
    end
  end

  // ----------------------------------------
  // link frame sender
  // ----------------------------------------
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} host_state_t;
  host_state_t hst_q; // sender state
  logic [23:0] tx_q; // bits still to send
  logic [4:0] bit_q; // falling edges sent
  logic [15:0] div_q; // half period / gap counter
  assign busy = (hst_q != H_IDLE);

  // shift out msb first, data changes on falling edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hst_q <= H_IDLE;
      tx_q <= 24'h000000;
      bit_q <= 5'h00;
      div_q <= 16'h0000;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
    end else begin
      case (hst_q)
        H_IDLE: begin
          if (start) begin
            tx_q <= {rx_mode_pkg::WRITE_OPCODE, c_addr, c_data};
            link.cs_n <= 1'b0;
            link.mosi <= rx_mode_pkg::WRITE_OPCODE[7];
            bit_q <= 5'h00;
            div_q <= 16'h0000;
            hst_q <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (div_q == 16'(SCLK_HALF - 1)) begin
            div_q <= 16'h0000;
            link.sclk <= ~link.sclk;
            if (link.sclk) begin
              tx_q <= {tx_q[22:0], 1'b0};
              link.mosi <= tx_q[22];
              bit_q <= bit_q + 5'h01;
              if (bit_q == 5'(rx_mode_pkg::FRAME_BITS - 1)) begin
                link.cs_n <= 1'b1;
                link.mosi <= 1'b0;
                hst_q <= H_GAP;
              end
            end
          end else begin
            div_q <= div_q + 16'h0001;
          end
        end
        H_GAP: begin
          // remaining settle time before reinit
          if (div_q == 16'(GAP_CYC - 1)) begin
            div_q <= 16'h0000;
            hst_q <= H_IDLE;
          end else begin
            div_q <= div_q + 16'h0001;
          end
        end
        default: begin
          hst_q <= H_IDLE;
        end
      endcase
    end
  end
endmodule // rx_mode_host
`default_nettype wire

/* File: hdl/rx_mode_pkg.sv */
// constants and types shared by the receiver mode controller and its host
// Overview of operation
// - mode select: 0 slave, 1 self polling
// - receiver enable: 0 sleep, 1 run slave
// - host enters run: select 0, enable 1
// - config select bit 3 picks A or B
// - run slave needs preamble and sync, no wakeup
// - interrupts at frame start, id match, end
// - host reconfigures only in sleep or hold
// - run entry waits for start-up sequencer
// - init state inits receiver, optional buffer clear
// - lock state: no data, no sync indications
// - sync loss returns to symbol sync wait
// - frame start clears buffer when enabled
// - id scan optional, else straight to end check
// - id miss restarts frame search, keeps bits
// - end criterion met: lock or resume sync wait
// - hold bit enters hold from states 3-10
// - hold clear goes to init, no start-up
// - host keeps 40 us before reinit
// - host refuses hold only while polling
// - sleep: rf off, low precision, start-up on exit
// - buffer gets payload only
`default_nettype none
package rx_mode_pkg;
  // ----------------------------------------
  // device register map (link addresses)
  // ----------------------------------------
  localparam logic [7:0] CHIP_MODE_CONTROL_0_ADDR = 8'h02;
  localparam logic [7:0] CHIP_MODE_CONTROL_1_ADDR = 8'h03;
  localparam logic [7:0] RX_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] CHIP_MODE_CONTROL_0_RESET = 8'h40;
  localparam logic [7:0] CHIP_MODE_CONTROL_1_RESET = 8'h00;
  localparam logic [7:0] RX_CONTROL_RESET = 8'h00;
  // chip_mode_control_0 fields
  localparam int OPERATING_MODE_SELECT_BIT = 0;
  localparam int SLAVE_RECEIVER_ENABLE_BIT = 1;
  localparam int SLAVE_CONFIG_SELECT_BIT = 3;
  localparam int CLKOUT_ENABLE_BIT = 6;
  // chip_mode_control_1 fields
  localparam int HOLD_BIT = 6;
  // rx_control fields
  localparam int INIT_BUFFER_ON_START_BIT = 0;
  localparam int FRAME_START_BUFFER_CLEAR_BIT = 1;
  localparam int MESSAGE_ID_SCAN_ENABLE_BIT = 2;
  localparam int BUFFER_LOCK_ENABLE_BIT = 3;
  // ----------------------------------------
  // link frame
  // ----------------------------------------
  localparam logic [7:0] WRITE_OPCODE = 8'h01;
  localparam int FRAME_BITS = 24;
  // ----------------------------------------
  // host registers (byte offsets on ahb-lite)
  // ----------------------------------------
  localparam logic [7:0] HOST_COMMAND_OFS = 8'h00;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_REFUSED_BIT = 1;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_CYC = 4;
  localparam int REINIT_GAP_NS = 40000;
  localparam int REINIT_GAP_CYC =
    (REINIT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // run mode slave states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_SLEEP, ST_STARTUP, ST_INIT, ST_LOCKED, ST_SYM_WAIT,
    ST_FRAME_WAIT, ST_BUF_INIT, ST_MID_CHECK, ST_MID_INIT,
    ST_MID_WAIT, ST_EOM_CHECK, ST_HOLD, ST_POLL
  } rx_state_t;
endpackage
`default_nettype wire

/* File: hdl/sync_2ff.sv */
// two flip-flop synchroniser for one level
`default_nettype none
module sync_2ff #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q; // first stage, read by second only
  // ----------------------------------------
  // two stages
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // sync_2ff
`default_nettype wire

/* File: tb/rx_link_assertions.sv */
// checker for the serial link between host controller and receiver
`default_nettype none
module rx_link_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // helper: link clock rises counted per frame
  // ----------------------------------------
  logic [5:0] rise_q; // rises since the frame opened
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_q <= 6'h00;
    end else if (cs_n) begin
      rise_q <= 6'h00; // idle link clears the count
    end else if ($rose(sclk)) begin
      rise_q <= rise_q + 6'h01;
    end
  end
  // ----------------------------------------
  // wire properties
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_idle_clock_low:
    assert property (cs_n |-> !sclk) else $error("link clock high while idle");
  a_high_phase_len:
    assert property ($rose(sclk) |-> sclk [*4]) else $error("short high phase");
  a_low_phase_len:
    assert property ($fell(sclk) |-> !sclk [*4]) else $error("short low phase");
  a_data_moves_low:
    assert property ($changed(mosi) && !cs_n |-> !sclk)
      else $error("data changed while clock high");
  a_data_held_high:
    assert property (sclk |-> $stable(mosi)) else $error("data moved in high");
  a_frame_bit_count:
    assert property ($rose(cs_n) |-> rise_q == 6'd24)
      else $error("frame without 24 clock rises");
  a_frame_span_bound:
    assert property ($fell(cs_n) |-> ##[180:210] $rose(cs_n))
      else $error("frame length out of range");
  a_write_opcode_msb:
    assert property ($fell(cs_n) |-> !mosi) else $error("opcode msb not 0");
  a_gap_after_frame:
    assert property ($rose(cs_n) |-> cs_n [*4]) else $error("frame gap short");
  // main scenarios seen
  c_frame_done: cover property ($rose(cs_n));
  c_full_count: cover property (rise_q == 6'd24);
  c_back_to_back: cover property ($rose(cs_n) ##[4:60] $fell(cs_n));
endmodule // rx_link_assertions
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench joining host controller and receiver over the link
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic hclk, hresetn, hsel, hwrite, hready, hresp, clr;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [8:0] din; // device side event inputs
  logic [7:0] seen_q; // sticky record of device pulses
  logic rf_enable, osc_low_precision, self_poll_enable, config_sel;
  logic clkout_enable, rx_init, buf_clear, buf_wr, buf_wr_bit, buf_lock;
  logic id_scan_init, irq_frame_start, irq_id_match, irq_eom;
  rx_mode_pkg::rx_state_t state;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  localparam logic [8:0] SU = 9'h100, SY = 9'h080, FS = 9'h040;
  localparam logic [8:0] IDD = 9'h020, IDV = 9'h010, EO = 9'h008;
  localparam logic [8:0] BV = 9'h004, BB = 9'h002, BR = 9'h001;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [6:0] q; // state, rf_enable, config_sel, self_poll_enable
  } row_t;
  row_t rows [6] = '{'{8'h02, 8'h48, {rx_mode_pkg::ST_SLEEP, 3'b010}},
    '{8'h02, 8'h4a, {rx_mode_pkg::ST_STARTUP, 3'b110}},
    '{8'h02, 8'h48, {rx_mode_pkg::ST_SLEEP, 3'b010}},
    '{8'h02, 8'h40, {rx_mode_pkg::ST_SLEEP, 3'b000}},
    '{8'h02, 8'h41, {rx_mode_pkg::ST_POLL, 3'b101}},
    '{8'h02, 8'h40, {rx_mode_pkg::ST_SLEEP, 3'b000}}};
  // ----------------------------------------
  // design, link and checker
  // ----------------------------------------
  rx_link_if lk();
  rx_mode_host #(.GAP_CYC(4)) u_rx_mode_host (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata, .link(lk));
  rx_mode_device u_rx_mode_device (.hclk, .hresetn, .link(lk),
    .startup_done(din[8]), .sym_sync(din[7]), .frame_sync(din[6]),
    .id_done(din[5]), .id_valid(din[4]), .eom_detect(din[3]),
    .rx_bit_valid(din[2]), .rx_bit(din[1]), .buffer_release(din[0]),
    .rf_enable, .osc_low_precision, .self_poll_enable, .config_sel,
    .clkout_enable, .rx_init, .buf_clear, .buf_wr, .buf_wr_bit, .buf_lock,
    .id_scan_init, .irq_frame_start, .irq_id_match, .irq_eom, .state);
  rx_link_assertions u_rx_link_assertions (.hclk(hclk), .hresetn(hresetn),
    .sclk(lk.sclk), .cs_n(lk.cs_n), .mosi(lk.mosi));
  // ----------------------------------------
  // clock, pulse recorder and timeout
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (clr) seen_q <= 8'h00;
    else seen_q <= seen_q | {rx_init, buf_clear, id_scan_init,
      irq_frame_start, irq_id_match, irq_eom, buf_wr, buf_wr & buf_wr_bit};
    if (cyc == 20000) begin
      bad_count++; // run hung
      summarize();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one single word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // send one device register write and wait for the link to go idle
  task automatic cmd(input logic [7:0] a, input logic [7:0] d);
    ahb(1'b1, 8'h00, {16'h0000, a, d}, r);
    do ahb(1'b0, 8'h04, 32'h0, r); while (r[0] !== 1'b0);
    wait_n(4);
  endtask
  task automatic clear_seen();
    @(posedge hclk) clr <= 1'b1;
    @(posedge hclk) clr <= 1'b0;
  endtask
  task automatic pulse(input logic [8:0] base, input logic [8:0] p);
    @(posedge hclk) din <= base | p;
    @(posedge hclk) din <= base;
    wait_n(6);
  endtask
  task automatic drv(input logic [8:0] v);
    @(posedge hclk) din <= v;
    wait_n(6);
  endtask
  task automatic look(input rx_mode_pkg::rx_state_t e, input logic [7:0] ev);
    chk({28'h0, state}, {28'h0, e});
    chk({24'h0, seen_q}, {24'h0, ev});
    clear_seen();
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    din = 9'h000;
    clr = 1'b0;
    wait_n(10);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({state, rf_enable, osc_low_precision, clkout_enable, buf_lock},
      {rx_mode_pkg::ST_SLEEP, 4'b0110});
    foreach (rows[i]) begin
      cmd(rows[i].a, rows[i].d);
      chk({25'h0, state, rf_enable, config_sel, self_poll_enable},
        {25'h0, rows[i].q});
    end
    clear_seen();
    cmd(8'h04, 8'h0f);
    cmd(8'h02, 8'h42);
    look(rx_mode_pkg::ST_STARTUP, 8'h00);
    drv(SU);
    look(rx_mode_pkg::ST_SYM_WAIT, 8'hc0);
    drv(SU | SY);
    look(rx_mode_pkg::ST_FRAME_WAIT, 8'h00);
    pulse(SU | SY, FS);
    look(rx_mode_pkg::ST_MID_WAIT, 8'h70);
    pulse(SU | SY, IDD);
    look(rx_mode_pkg::ST_FRAME_WAIT, 8'h00);
    pulse(SU | SY, FS);
    pulse(SU | SY, IDD | IDV);
    look(rx_mode_pkg::ST_EOM_CHECK, 8'h78);
    pulse(SU | SY, BV | BB);
    look(rx_mode_pkg::ST_EOM_CHECK, 8'h03);
    pulse(SU | SY, EO);
    chk({31'h0, buf_lock}, 32'h1);
    look(rx_mode_pkg::ST_LOCKED, 8'h04);
    pulse(SU | SY, FS | BV);
    look(rx_mode_pkg::ST_LOCKED, 8'h00);
    // config write while running is refused and flagged
    cmd(8'h04, 8'h0f);
    ahb(1'b0, 8'h04, 32'h0, r);
    chk(r & 32'h00ffff03, 32'h00004202);
    ahb(1'b0, 8'h00, 32'h0, r);
    chk(r, 32'h00000242);
    ahb(1'b0, 8'h08, 32'h0, r);
    chk(r, 32'h0);
    ahb(1'b1, 8'h04, 32'h2, r);
    ahb(1'b0, 8'h04, 32'h0, r);
    chk(r & 32'h2, 32'h0);
    pulse(SU | SY, BR);
    clear_seen();
    cmd(8'h03, 8'h40);
    wait_n(20);
    look(rx_mode_pkg::ST_HOLD, 8'h00);
    drv(SY);
    cmd(8'h03, 8'h00);
    look(rx_mode_pkg::ST_FRAME_WAIT, 8'hc0);
    drv(9'h000);
    look(rx_mode_pkg::ST_SYM_WAIT, 8'h00);
    cmd(8'h02, 8'h40);
    chk({30'h0, rf_enable, osc_low_precision}, 32'h1);
    // hold request while polling is refused by the host controller
    cmd(8'h02, 8'h41);
    cmd(8'h03, 8'h40);
    ahb(1'b0, 8'h04, 32'h0, r);
    chk(r & 32'h00ff0003, 32'h00000002);
    chk({31'h0, hresp}, 32'h0);
    summarize();
  end
endmodule // testbench
`default_nettype wire
